// ==== cocr_defs.vh ====
// Purpose: constants for the clock output control register bank
// Assumes: byte offsets are register indexes on the serial bus
// Notes:   reset values are the power-up defaults of each writable byte
`ifndef COCR_DEFS_VH
`define COCR_DEFS_VH
`define COCR_OFS_PCI_GATE      8'h02
`define COCR_OFS_FPCI_48M      8'h03
`define COCR_OFS_HUB_GATE      8'h04
`define COCR_OFS_SPREAD_DELAY  8'h05
`define COCR_OFS_SIGNATURE     8'h06
`define COCR_OFS_RESERVED      8'h07
`define COCR_OFS_FB_DIV        8'h08
`define COCR_OFS_REF_DIV       8'h09
`define COCR_RST_PCI_GATE      8'h7F
`define COCR_RST_FPCI_48M      8'hC7
`define COCR_RST_HUB_GATE      8'h3F
`define COCR_RST_SPREAD_DELAY  8'h40
`define COCR_RST_FB_DIV        8'h00
`define COCR_RST_REF_DIV       8'h00
`define COCR_WMASK_HUB_GATE    8'hBF
`define COCR_WMASK_SPREAD      8'hF5
`define COCR_WMASK_DIV         8'h7F
`define COCR_SLAVE_ADDR7       7'h69
`define COCR_REG_COUNT         10
`endif

// ==== cocr_gate_sync.v ====
// Purpose: per-output gate that changes only while the clock is low
// Assumes: clk_in levels are sampled on clk
// Notes:   keeps enable changes from chopping a pulse
`timescale 1ns/1ps
`default_nettype none
module cocr_gate_sync #(
   parameter N = 8
) (
   input  wire         clk,
   input  wire         rst,
   input  wire [N-1:0] clk_in,
   input  wire [N-1:0] en_req,
   output reg  [N-1:0] en_applied
);
   reg [N-1:0] s1_reg;
   reg [N-1:0] s2_reg;
   genvar i;
   generate
      for (i = 0; i < N; i = i + 1)
      begin : g_bit
         always @(posedge clk or posedge rst)
         begin
            if (rst)
            begin
               s1_reg[i]     <= 1'b0;
               s2_reg[i]     <= 1'b0;
               en_applied[i] <= 1'b1;
            end
            else
            begin
               s1_reg[i] <= clk_in[i];
               s2_reg[i] <= s1_reg[i];
               if (!s2_reg[i])
                  en_applied[i] <= en_req[i];
            end
         end
      end
   endgenerate
endmodule // cocr_gate_sync
`default_nettype wire

// ==== cocr_regs.v ====
// Purpose: serial-bus control bytes 2..9 of a clock synthesizer
// Assumes: two-wire slave pins; scl/sda sampled by two flops on clk
// Notes:   block write with command and byte count bytes; block read without them
// Notes on behaviour
// - byte2 bit7 reference strength, 0 high
// - byte2 bits6..0 gate seven PCI outputs
// - byte3 bits7,6 gate dot and USB
// - byte3 bits5..3 make free PCI stoppable
// - byte3 bits2..0 gate free PCI outputs
// - byte4 bit7 spread high select bit
// - byte4 bits5..0 enable six hub outputs
// - byte5 bits7,6 spread mid/low bits
// - byte5 bits5,4 hub input delay setting
// - byte5 bit2 slows dot edges 15%
// - byte5 bit0 slows USB edges
// - bytes 2,3 read back as written; byte4 bit6 and byte5 bits3,1 read 0
// - byte6 read-only revision and vendor code
// - signature writes acked and discarded
// - byte8 bits6..0 feedback divider value
// - byte9 bits6..1 reference divider value
// - byte9 bit0 selects ROM or programmed dividers
// - derived clocks keep ratios to CPU
// - spread code chooses down or center profile
// - command and count bytes, then data from 0
// - answer own address only; keep values
`timescale 1ns/1ps
`default_nettype none
`include "cocr_defs.vh"
module cocr_regs #(
   parameter [7:0] REVISION    = 8'h05, // arbitrary value
   parameter [7:0] VENDOR_CODE = 8'h0A  // arbitrary value
) (
   input  wire        clk,
   input  wire        rst,
   input  wire        scl_in,
   input  wire        sda_in,
   output reg         sda_out,
   output reg         sda_oe,
   input  wire        pci_clock_stop_n,
   input  wire [6:0]  pci_clk_raw,
   input  wire [2:0]  free_pci_clk_raw,
   input  wire        dot_clock_48m_raw,
   input  wire        usb_clock_48m_raw,
   input  wire [5:0]  hub_clock_66m_raw,
   output reg         ref_low_strength,
   output reg  [6:0]  pci_enable,
   output reg  [2:0]  free_pci_enable,
   output reg         dot_clock_48m_enable,
   output reg         usb_clock_48m_enable,
   output reg  [5:0]  hub_clock_66m_enable,
   output reg  [2:0]  spread_select,
   output reg         spread_center,
   output reg  [1:0]  hub_input_delay,
   output reg         dot_slow_edge,
   output reg         usb_slow_edge,
   output reg  [6:0]  feedback_divider_bits,
   output reg  [5:0]  reference_divider_bits,
   output reg         divider_source_select
);
   localparam [5:0] ST_IDLE = 6'h01;
   localparam [5:0] ST_ADDR = 6'h02;
   localparam [5:0] ST_RX   = 6'h04;
   localparam [5:0] ST_ACK  = 6'h08;
   localparam [5:0] ST_TX   = 6'h10;
   localparam [5:0] ST_RACK = 6'h20;

   reg [7:0] pci_gate_reg;
   reg [7:0] fpci_reg;
   reg [7:0] hub_reg;
   reg [7:0] spread_reg;
   reg [7:0] fb_reg;
   reg [7:0] ref_reg;
   reg [1:0] scl_s_reg;
   reg [1:0] sda_s_reg;
   reg       scl_d_reg;
   reg       sda_d_reg;
   reg [5:0] st_reg;
   reg [3:0] bit_reg;
   reg [7:0] sh_reg;
   reg [1:0] phase_reg;
   reg       rd_reg;
   reg [7:0] idx_reg;
   reg [7:0] tx_reg;
   reg       nack_reg;
   reg [7:0] rd_data;

   wire scl = scl_s_reg[1];
   wire sda = sda_s_reg[1];
   wire scl_rise = scl & ~scl_d_reg;
   wire scl_fall = ~scl & scl_d_reg;
   wire start_c = scl & scl_d_reg & sda_d_reg & ~sda;
   wire stop_c  = scl & scl_d_reg & ~sda_d_reg & sda;
   wire [7:0] rx_byte = {sh_reg[6:0], sda};

   always @*
   begin
      case (idx_reg)
         `COCR_OFS_PCI_GATE:     rd_data = pci_gate_reg;
         `COCR_OFS_FPCI_48M:     rd_data = fpci_reg;
         `COCR_OFS_HUB_GATE:     rd_data = hub_reg;
         `COCR_OFS_SPREAD_DELAY: rd_data = spread_reg;
         `COCR_OFS_SIGNATURE:
            rd_data = {REVISION[3:0], VENDOR_CODE[3:0]};
         `COCR_OFS_FB_DIV:       rd_data = fb_reg;
         `COCR_OFS_REF_DIV:      rd_data = ref_reg;
         default:                rd_data = 8'h00;
      endcase
   end

   always @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         scl_s_reg <= 2'h3;
         sda_s_reg <= 2'h3;
         scl_d_reg <= 1'b1;
         sda_d_reg <= 1'b1;
      end
      else
      begin
         scl_s_reg <= {scl_s_reg[0], scl_in};
         sda_s_reg <= {sda_s_reg[0], sda_in};
         scl_d_reg <= scl;
         sda_d_reg <= sda;
      end
   end

   always @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         pci_gate_reg <= `COCR_RST_PCI_GATE;
         fpci_reg     <= `COCR_RST_FPCI_48M;
         hub_reg      <= `COCR_RST_HUB_GATE;
         spread_reg   <= `COCR_RST_SPREAD_DELAY;
         fb_reg       <= `COCR_RST_FB_DIV;
         ref_reg      <= `COCR_RST_REF_DIV;
         st_reg       <= ST_IDLE;
         bit_reg      <= 4'h0;
         sh_reg       <= 8'h00;
         phase_reg    <= 2'h0;
         rd_reg       <= 1'b0;
         idx_reg      <= 8'h00;
         tx_reg       <= 8'h00;
         nack_reg     <= 1'b0;
         sda_out      <= 1'b0;
         sda_oe       <= 1'b0;
      end
      else if (start_c)
      begin
         st_reg  <= ST_ADDR;
         bit_reg <= 4'h0;
         sda_oe  <= 1'b0;
      end
      else if (stop_c)
      begin
         st_reg <= ST_IDLE;
         sda_oe <= 1'b0;
      end
      else
      begin
         case (st_reg)
            ST_IDLE:
               sda_oe <= 1'b0;
            ST_ADDR, ST_RX:
               if (scl_rise)
               begin
                  sh_reg  <= rx_byte;
                  bit_reg <= bit_reg + 4'h1;
                  if (bit_reg == 4'h7)
                  begin
                     bit_reg <= 4'h0;
                     st_reg  <= ST_ACK;
                     if (st_reg == ST_ADDR)
                     begin
                        nack_reg  <= (rx_byte[7:1] != `COCR_SLAVE_ADDR7);
                        rd_reg    <= rx_byte[0];
                        phase_reg <= rx_byte[0] ? 2'h2 : 2'h0;
                        idx_reg   <= 8'h00;
                     end
                     else
                     begin
                        nack_reg <= 1'b0;
                        if (phase_reg != 2'h2)
                           phase_reg <= phase_reg + 2'h1;
                        else
                        begin
                           idx_reg <= idx_reg + 8'h01;
                           case (idx_reg)
                              `COCR_OFS_PCI_GATE:
                                 pci_gate_reg <= rx_byte;
                              `COCR_OFS_FPCI_48M:
                                 fpci_reg <= rx_byte;
                              `COCR_OFS_HUB_GATE:
                                 hub_reg <= rx_byte &
                                    `COCR_WMASK_HUB_GATE;
                              `COCR_OFS_SPREAD_DELAY:
                                 spread_reg <= rx_byte &
                                    `COCR_WMASK_SPREAD;
                              `COCR_OFS_FB_DIV:
                                 fb_reg <= rx_byte &
                                    `COCR_WMASK_DIV;
                              `COCR_OFS_REF_DIV:
                                 ref_reg <= rx_byte &
                                    `COCR_WMASK_DIV;
                              default:
                                 fb_reg <= fb_reg;
                           endcase
                        end
                     end
                  end
               end
            ST_ACK:
               if (scl_fall)
               begin
                  if (!sda_oe && phase_reg != 2'h3)
                  begin
                     sda_oe  <= ~nack_reg;
                     sda_out <= 1'b0;
                  end
                  else if (rd_reg && phase_reg[1])
                  begin
                     tx_reg  <= rd_data;
                     sda_out <= rd_data[7];
                     sda_oe  <= 1'b1;
                     idx_reg <= idx_reg + 8'h01;
                     st_reg  <= ST_TX;
                  end
                  else
                  begin
                     sda_oe <= 1'b0;
                     st_reg <= nack_reg ? ST_IDLE : ST_RX;
                  end
               end
            ST_TX:
               if (scl_fall)
               begin
                  bit_reg <= bit_reg + 4'h1;
                  if (bit_reg == 4'h7)
                  begin
                     bit_reg <= 4'h0;
                     sda_oe  <= 1'b0;
                     st_reg  <= ST_RACK;
                  end
                  else
                  begin
                     tx_reg  <= {tx_reg[6:0], 1'b0};
                     sda_out <= tx_reg[6];
                  end
               end
            ST_RACK:
               if (scl_rise)
               begin
                  if (sda)
                     st_reg <= ST_IDLE;
                  else
                  begin
                     tx_reg    <= rd_data;
                     st_reg    <= ST_ACK;
                     phase_reg <= 2'h3; // host ack: next byte, no drive
                  end
               end
            default:
               st_reg <= ST_IDLE;
         endcase
      end
   end

   wire [6:0] pci_en_w;
   wire [2:0] fpci_en_w;
   wire [1:0] m48_en_w;
   wire [5:0] hub_en_w;
   reg  [1:0] pci_stop_s_reg;
   wire [2:0] fpci_req = fpci_reg[2:0] &
      ~(fpci_reg[5:3] & {3{~pci_stop_s_reg[1]}});

   always @(posedge clk or posedge rst)
   begin
      if (rst)
         pci_stop_s_reg <= 2'h3;
      else
         pci_stop_s_reg <= {pci_stop_s_reg[0], pci_clock_stop_n};
   end

   cocr_gate_sync #(.N(18)) u_gate (
      .clk        (clk),
      .rst        (rst),
      .clk_in     ({pci_clk_raw, free_pci_clk_raw, dot_clock_48m_raw,
                    usb_clock_48m_raw, hub_clock_66m_raw}),
      .en_req     ({pci_gate_reg[6:0], fpci_req, fpci_reg[7:6],
                    hub_reg[5:0]}),
      .en_applied ({pci_en_w, fpci_en_w, m48_en_w, hub_en_w})
   );

   always @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         ref_low_strength       <= 1'b0;
         pci_enable             <= 7'h7F;
         free_pci_enable        <= 3'h7;
         dot_clock_48m_enable   <= 1'b1;
         usb_clock_48m_enable   <= 1'b1;
         hub_clock_66m_enable   <= 6'h3F;
         spread_select          <= 3'h1;
         spread_center          <= 1'b0;
         hub_input_delay        <= 2'h0;
         dot_slow_edge          <= 1'b0;
         usb_slow_edge          <= 1'b0;
         feedback_divider_bits  <= 7'h00;
         reference_divider_bits <= 6'h00;
         divider_source_select  <= 1'b0;
      end
      else
      begin
         ref_low_strength       <= pci_gate_reg[7];
         pci_enable             <= pci_en_w;
         free_pci_enable        <= fpci_en_w;
         dot_clock_48m_enable   <= m48_en_w[1];
         usb_clock_48m_enable   <= m48_en_w[0];
         hub_clock_66m_enable   <= hub_en_w;
         spread_select <= {hub_reg[7], spread_reg[7:6]};
         spread_center          <= hub_reg[7];
         hub_input_delay        <= spread_reg[5:4];
         dot_slow_edge          <= spread_reg[2];
         usb_slow_edge          <= spread_reg[0];
         feedback_divider_bits  <= fb_reg[6:0];
         reference_divider_bits <= ref_reg[6:1];
         divider_source_select  <= ref_reg[0];
      end
   end
endmodule // cocr_regs
`default_nettype wire

// ==== cocr_regs_monitor.sv ====
// Purpose: concurrent checks on the control byte bank pins
// Assumes: bus quarter bit lasts several clk cycles
// Notes:   bound to every cocr_regs instance
`timescale 1ns/1ps
`default_nettype none
module cocr_regs_monitor (
   input wire logic       clk,
   input wire logic       rst,
   input wire logic       scl_in,
   input wire logic       sda_oe,
   input wire logic [6:0] pci_clk_raw,
   input wire logic [5:0] hub_clock_66m_raw,
   input wire logic [6:0] pci_enable,
   input wire logic       dot_clock_48m_enable,
   input wire logic       usb_clock_48m_enable,
   input wire logic [5:0] hub_clock_66m_enable,
   input wire logic [2:0] spread_select,
   input wire logic       spread_center,
   input wire logic [6:0] feedback_divider_bits,
   input wire logic [5:0] reference_divider_bits,
   input wire logic       divider_source_select
);
   default clocking cb @(posedge clk);
   endclocking
   a_reset_gates_on: assert property (
      rst && $past(rst) |-> pci_enable == 7'h7F
      && hub_clock_66m_enable == 6'h3F
      && dot_clock_48m_enable && usb_clock_48m_enable)
      else $error("gates not at default in reset");
   a_reset_spread_code: assert property (
      rst && $past(rst) |-> spread_select == 3'h1 && !spread_center)
      else $error("spread code not at default in reset");
   a_reset_dividers: assert property (
      rst && $past(rst) |-> feedback_divider_bits == 7'h00
      && reference_divider_bits == 6'h00 && !divider_source_select)
      else $error("dividers not at default in reset");
   a_center_from_code: assert property (
      disable iff (rst) spread_center == spread_select[2])
      else $error("center flag differs from top spread bit");
   a_pci_gate_low: assert property (
      disable iff (rst) ((pci_enable ^ $past(pci_enable))
      & $past(pci_clk_raw) & $past(pci_clk_raw, 2)
      & $past(pci_clk_raw, 3) & $past(pci_clk_raw, 4)) == 7'h00)
      else $error("pci gate changed while clock high");
   a_hub_gate_low: assert property (
      disable iff (rst) ((hub_clock_66m_enable ^ $past(hub_clock_66m_enable))
      & $past(hub_clock_66m_raw) & $past(hub_clock_66m_raw, 2)
      & $past(hub_clock_66m_raw, 3) & $past(hub_clock_66m_raw, 4)) == 6'h00)
      else $error("hub gate changed while clock high");
   a_sda_scl_low: assert property (
      disable iff (rst) $changed(sda_oe) |-> !scl_in && !$past(scl_in))
      else $error("data line moved while bus clock high");
   a_ack_held: assert property (
      disable iff (rst) $rose(sda_oe) |-> sda_oe [*8])
      else $error("data line drive too short");
endmodule // cocr_regs_monitor
bind cocr_regs cocr_regs_monitor i_mon (
   .clk(clk), .rst(rst), .scl_in(scl_in), .sda_oe(sda_oe),
   .pci_clk_raw(pci_clk_raw), .hub_clock_66m_raw(hub_clock_66m_raw),
   .pci_enable(pci_enable), .dot_clock_48m_enable(dot_clock_48m_enable),
   .usb_clock_48m_enable(usb_clock_48m_enable),
   .hub_clock_66m_enable(hub_clock_66m_enable),
   .spread_select(spread_select), .spread_center(spread_center),
   .feedback_divider_bits(feedback_divider_bits),
   .reference_divider_bits(reference_divider_bits),
   .divider_source_select(divider_source_select));
`default_nettype wire

// ==== cocr_host_model.sv ====
// Purpose: two-wire bus host framing block reads and writes
// Assumes: data line pulled up; parties only pull it low
// Notes:   Q is a quarter bit time in clk cycles
`timescale 1ns/1ps
`default_nettype none
module cocr_host_model (
   input  wire logic clk,
   input  wire logic sda_line,
   output var  logic scl_drv,
   output var  logic sda_low
);
   localparam int Q = 6;
   logic [7:0] data_q [0:9];
   initial
   begin
      scl_drv = 1'b1;
      sda_low = 1'b0;
   end
   task automatic w(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask
   task automatic bit_xfer(input logic b, output logic r);
      w(Q);
      sda_low = ~b;
      w(Q);
      scl_drv = 1'b1;
      w(Q);
      r = sda_line;
      w(Q);
      scl_drv = 1'b0;
   endtask
   task automatic byte_xfer(input logic [7:0] d, input logic last,
                            output logic [7:0] r, output logic ack);
      logic b;
      for (int i = 7; i >= 0; i--)
      begin
         bit_xfer(d[i], b);
         r[i] = b;
      end
      bit_xfer(last, ack);
   endtask
   task automatic frame(input logic [7:0] addr, input int n,
                        output logic nack);
      logic [7:0] r;
      logic       a;
      w(2 * Q);
      sda_low = 1'b1;
      w(2 * Q);
      scl_drv = 1'b0;
      byte_xfer(addr, 1'b1, r, nack);
      if (!addr[0])
      begin
         byte_xfer(8'h00, 1'b1, r, a);
         nack |= a;
         byte_xfer(8'(n), 1'b1, r, a);
         nack |= a;
      end
      for (int i = 0; i < n; i++)
      begin
         if (addr[0])
            byte_xfer(8'hFF, i == n - 1, data_q[i], a);
         else
            byte_xfer(data_q[i], 1'b1, r, a);
         nack |= a & ~addr[0];
      end
      w(Q);
      sda_low = 1'b1;
      w(Q);
      scl_drv = 1'b1;
      w(2 * Q);
      sda_low = 1'b0;
      w(4 * Q);
   endtask
endmodule // cocr_host_model
`default_nettype wire

// ==== cocr_regs_tb.sv ====
// Purpose: self-checking bench for the clock output control bytes
// Assumes: host model frames transfers; raw clocks from a divider
// Notes:   signature reads as revision and vendor low nibbles
`timescale 1ns/1ps
`default_nettype none
module cocr_regs_tb;
   logic       clk, rst, stop_n, scl, sda_low, sda_out, sda_oe;
   logic       ref_low_strength, dot_en, usb_en, spread_center;
   logic       dot_slow_edge, usb_slow_edge, div_src;
   logic [3:0] div;
   logic [6:0] pci_enable, fb_div;
   logic [2:0] free_pci_enable, spread_select;
   logic [5:0] hub_enable, ref_div;
   logic [1:0] hub_input_delay;
   logic [7:0] exp_q [0:9];
   int         failures, comparisons;
   wire        sda_line;
   wire [6:0]  pci_raw  = {7{div[3]}};
   wire [2:0]  fpci_raw = {div[2], div[3], div[1]};
   wire        dot_raw  = div[3];
   wire        usb_raw  = div[1];
   wire [5:0]  hub_raw  = {6{div[2]}};
   // open drain: the device only pulls low when it drives a zero
   assign sda_line = ~(sda_low | (sda_oe & ~sda_out));
   initial
   begin
      clk = 1'b0;
      div = 4'h0;
      forever #10 clk = ~clk;
   end
   always @(posedge clk) div <= #1 div + 4'h1;
   cocr_regs #(.REVISION(8'h06), .VENDOR_CODE(8'h0C)) i_dut (
      .clk(clk), .rst(rst), .scl_in(scl), .sda_in(sda_line),
      .sda_out(sda_out), .sda_oe(sda_oe), .pci_clock_stop_n(stop_n),
      .pci_clk_raw(pci_raw), .free_pci_clk_raw(fpci_raw),
      .dot_clock_48m_raw(dot_raw), .usb_clock_48m_raw(usb_raw),
      .hub_clock_66m_raw(hub_raw), .ref_low_strength(ref_low_strength),
      .pci_enable(pci_enable), .free_pci_enable(free_pci_enable),
      .dot_clock_48m_enable(dot_en), .usb_clock_48m_enable(usb_en),
      .hub_clock_66m_enable(hub_enable), .spread_select(spread_select),
      .spread_center(spread_center), .hub_input_delay(hub_input_delay),
      .dot_slow_edge(dot_slow_edge), .usb_slow_edge(usb_slow_edge),
      .feedback_divider_bits(fb_div), .reference_divider_bits(ref_div),
      .divider_source_select(div_src));
   cocr_host_model i_host (.clk(clk), .sda_line(sda_line), .scl_drv(scl),
      .sda_low(sda_low));
   task automatic check(input string what, input logic [7:0] seen,
                        input logic [7:0] exp);
      comparisons++;
      if (seen !== exp)
      begin
         failures++;
         $display("wrong value %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic report_and_stop;
      if (failures == 0 && comparisons > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask
   task automatic read_compare;
      logic nack;
      i_host.frame(8'hD3, 10, nack);
      check("read address ack", nack, 1'b0);
      for (int i = 0; i < 10; i++)
         check("read byte", i_host.data_q[i], exp_q[i]);
   endtask
   task automatic t_defaults;
      exp_q = '{8'h00, 8'h00, 8'h7F, 8'hC7, 8'h3F, 8'h40, 8'h6C, 8'h00,
                8'h00, 8'h00};
      read_compare;
      check("ref and pci", {ref_low_strength, pci_enable}, 8'h7F);
   endtask
   task automatic t_write_read;
      logic nack;
      exp_q = '{8'h00, 8'h00, 8'hA5, 8'h7A, 8'hA5, 8'hB5, 8'h6C, 8'h00,
                8'h55, 8'h2B};
      i_host.data_q = '{8'h11, 8'h22, 8'hA5, 8'h7A, 8'hA5, 8'hB5, 8'hFF,
                        8'h00, 8'h55, 8'h2B};
      i_host.frame(8'hD2, 10, nack);
      check("write acks", nack, 1'b0);
      check("ref and pci", {ref_low_strength, pci_enable}, 8'hA5);
      check("48m free", {dot_en, usb_en, free_pci_enable}, 5'h0A);
      check("hub gates", hub_enable, 6'h25);
      check("spread", {spread_center, spread_select}, 4'hE);
      check("delay edges", {hub_input_delay, dot_slow_edge, usb_slow_edge},
            4'hF);
      check("feedback", fb_div, 7'h55);
      check("reference", {ref_div, div_src}, 7'h2B);
      read_compare;
   endtask
   task automatic t_free_stop;
      logic nack;
      stop_n = 1'b0;
      i_host.w(24);
      check("stopped free pci", free_pci_enable, 3'h0);
      i_host.data_q[3] = 8'h1F;
      i_host.frame(8'hD2, 4, nack);
      check("part stoppable", free_pci_enable, 3'h4);
      stop_n = 1'b1;
      i_host.w(24);
      check("free pci resumed", free_pci_enable, 3'h7);
   endtask
   task automatic t_wrong_addr;
      logic nack;
      i_host.data_q[2] = 8'h00;
      i_host.frame(8'hD4, 4, nack);
      check("foreign address", nack, 1'b1);
      check("pci kept", pci_enable, 7'h25);
   endtask
   initial
   begin
      repeat (60000) @(posedge clk);
      failures++;
      report_and_stop;
   end
   initial
   begin
      rst = 1'b1;
      stop_n = 1'b1;
      failures = 0;
      comparisons = 0;
      repeat (5) @(posedge clk);
      #1 rst = 1'b0;
      i_host.w(8);
      t_defaults;
      t_write_read;
      t_free_stop;
      t_wrong_addr;
      rst = 1'b1;
      i_host.w(2);
      rst = 1'b0;
      i_host.w(8);
      t_defaults;
      report_and_stop;
   end
endmodule // cocr_regs_tb
`default_nettype wire
